// File: verilog/spi_chain_pkg.sv
package spi_chain_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam int CTRL_BITS  = 8;
  localparam int DATA_BITS  = FRAME_BITS - CTRL_BITS;
  localparam int MSB        = FRAME_BITS - 1;

  typedef struct packed {
    logic [CTRL_BITS-1:0] ctrl;
    logic [DATA_BITS-1:0] data;
  } frame_t;

  localparam frame_t FRAME_ZERO = '{ctrl: 8'h00, data: 24'h000000};

  // ----------------------------------------------------------------
  // Pin synchroniser and buffer
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES  = 3;
  localparam int BUFFER_DEPTH = 2;

  // ----------------------------------------------------------------
  // Interrupt pin drive
  // ----------------------------------------------------------------
  localparam logic DRIVE_PUSH_PULL  = 1'b1;
  localparam logic DRIVE_OPEN_DRAIN = 1'b0;

endpackage

// File: verilog/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  import spi_chain_pkg::*;

  // ----------------------------------------------------------------
  // Three stages, the level moves once the last two agree
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] stage_r;
  logic [SYNC_STAGES-1:0] stage_nxt;
  logic                   level_r;
  logic                   level_nxt;

  always_comb begin
    stage_nxt = {stage_r[SYNC_STAGES-2:0], pin};
    level_nxt = level_r;
    if (stage_r[1] == stage_r[2]) begin
      level_nxt = stage_r[2];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_r <= {SYNC_STAGES{RESET_LEVEL}};
      level_r <= RESET_LEVEL;
    end else begin
      stage_r <= stage_nxt;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;

endmodule

// File: verilog/pair_buffer.sv
`timescale 1ns/1ps
module pair_buffer (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  spi_chain_pkg::frame_t in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output spi_chain_pkg::frame_t out_data
);
  import spi_chain_pkg::*;

  // ----------------------------------------------------------------
  // Head register feeds the output, tail holds the second entry
  // ----------------------------------------------------------------
  frame_t     head_r;
  frame_t     head_nxt;
  frame_t     tail_r;
  frame_t     tail_nxt;
  logic [1:0] count_r;
  logic [1:0] count_nxt;
  logic       push;
  logic       pop;
  logic       valid_r;
  logic       valid_nxt;

  always_comb begin
    push      = in_valid && (count_r != 2'(BUFFER_DEPTH));
    pop       = out_ready && (count_r != 2'h0);
    head_nxt  = head_r;
    tail_nxt  = tail_r;
    count_nxt = count_r;
    unique case ({push, pop})
      2'b10: begin
        if (count_r == 2'h0) begin
          head_nxt = in_data;
        end else begin
          tail_nxt = in_data;
        end
        count_nxt = count_r + 2'h1;
      end
      2'b01: begin
        head_nxt  = tail_r;
        count_nxt = count_r - 2'h1;
      end
      2'b11: begin
        if (count_r == 2'h1) begin
          head_nxt = in_data;
        end else begin
          head_nxt = tail_r;
          tail_nxt = in_data;
        end
      end
      2'b00: begin
      end
    endcase
    valid_nxt = (count_nxt != 2'h0);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      head_r  <= FRAME_ZERO;
      tail_r  <= FRAME_ZERO;
      count_r <= 2'h0;
      valid_r <= 1'b0;
    end else begin
      head_r  <= head_nxt;
      tail_r  <= tail_nxt;
      count_r <= count_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign in_ready  = (count_r != 2'(BUFFER_DEPTH));
  assign out_valid = valid_r;
  assign out_data  = head_r;

endmodule

// File: verilog/spi_chain_slave.sv
`timescale 1ns/1ps
module spi_chain_slave (
  input  wire logic             SYS_CLK,
  input  wire logic             RST,
  input  wire logic             SERIAL_CLK,
  input  wire logic             SLAVE_SELECT_N,
  input  wire logic             SLAVE_IN,
  output logic                  SLAVE_OUT_O,
  output logic                  SLAVE_OUT_OE,
  input  spi_chain_pkg::frame_t REPLY_DATA,
  output logic                  CMD_VALID,
  input  wire logic             CMD_READY,
  output spi_chain_pkg::frame_t CMD_DATA,
  output logic                  CMD_OVERRUN,
  input  wire logic             IRQ_REQUEST,
  input  wire logic             IRQ_PUSH_PULL,
  output logic                  INTERRUPT_REQUEST_N_O,
  output logic                  INTERRUPT_REQUEST_N_OE
);
  import spi_chain_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic frame_t shift_in(input frame_t word,
                                      input logic   bit_in);
    return {word[MSB-1:0], bit_in};
  endfunction

  function automatic logic level_edge(input logic prev,
                                      input logic now,
                                      input logic to);
    return (prev != to) && (now == to);
  endfunction

  // ----------------------------------------------------------------
  // Link domain: start flag and output held in reset whenever select is high, shift stage only by RST
  // ----------------------------------------------------------------
  logic   link_rst;
  frame_t shift_r;
  frame_t shift_nxt;
  logic   started_r;
  logic   started_nxt;
  logic   so_r;
  logic   so_nxt;
  logic   so_oe_r;
  logic   so_oe_nxt;
  frame_t reply_r;

  assign link_rst = RST | SLAVE_SELECT_N;

  // Rising edge: first edge loads the reply, later edges shift
  always_comb begin
    started_nxt = 1'b1;
    if (SLAVE_SELECT_N) begin
      shift_nxt = shift_r;
    end else if (started_r) begin
      shift_nxt = shift_in(shift_r, SLAVE_IN);
    end else begin
      shift_nxt = shift_in(reply_r, SLAVE_IN);
    end
  end

  always_ff @(posedge SERIAL_CLK or posedge link_rst) begin
    if (link_rst) begin
      started_r <= 1'b0;
    end else begin
      started_r <= started_nxt;
    end
  end

  // Shift stage keeps its content after the frame for execution
  always_ff @(posedge SERIAL_CLK or posedge RST) begin
    if (RST) begin
      shift_r <= FRAME_ZERO;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // Falling edge: output the next bit
  always_comb begin
    so_oe_nxt = 1'b1;
    if (started_r) begin
      so_nxt = shift_r[MSB];
    end else begin
      so_nxt = reply_r[MSB];
    end
  end

  always_ff @(negedge SERIAL_CLK or posedge link_rst) begin
    if (link_rst) begin
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
    end else begin
      so_r    <= so_nxt;
      so_oe_r <= so_oe_nxt;
    end
  end

  assign SLAVE_OUT_O  = so_r;
  assign SLAVE_OUT_OE = so_oe_r;

  // ----------------------------------------------------------------
  // Select synchroniser into the system domain
  // ----------------------------------------------------------------
  logic sel_n_sync;
  logic sel_n_prev_r;
  logic frame_open;
  logic frame_close;

  pin_sync #(
    .RESET_LEVEL (1'b1)
  ) u_sel_sync (
    .clk   (SYS_CLK),
    .rst   (RST),
    .pin   (SLAVE_SELECT_N),
    .level (sel_n_sync)
  );

  assign frame_open  = level_edge(sel_n_prev_r, sel_n_sync, 1'b0);
  assign frame_close = level_edge(sel_n_prev_r, sel_n_sync, 1'b1);

  // ----------------------------------------------------------------
  // Reply capture at frame start
  // ----------------------------------------------------------------
  frame_t reply_nxt;

  always_comb begin
    reply_nxt = reply_r;
    if (frame_open) begin
      reply_nxt = REPLY_DATA;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sel_n_prev_r <= 1'b1;
      reply_r      <= FRAME_ZERO;
    end else begin
      sel_n_prev_r <= sel_n_sync;
      reply_r      <= reply_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Command word into the system domain, two samples deep
  // ----------------------------------------------------------------
  frame_t word_a_r;
  frame_t word_a_nxt;
  frame_t word_b_r;
  frame_t word_b_nxt;

  always_comb begin
    word_a_nxt = shift_r;
    word_b_nxt = word_a_r;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      word_a_r <= FRAME_ZERO;
      word_b_r <= FRAME_ZERO;
    end else begin
      word_a_r <= word_a_nxt;
      word_b_r <= word_b_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Command hand-off at frame end
  // ----------------------------------------------------------------
  logic   pend_r;
  logic   pend_nxt;
  frame_t pend_word_r;
  frame_t pend_word_nxt;
  logic   overrun_r;
  logic   overrun_nxt;
  logic   buf_in_ready;
  logic   buf_out_valid;
  frame_t buf_out_data;

  always_comb begin
    pend_nxt      = pend_r;
    pend_word_nxt = pend_word_r;
    overrun_nxt   = 1'b0;
    if (pend_r && buf_in_ready) begin
      pend_nxt = 1'b0;
    end
    if (frame_close) begin
      pend_nxt      = 1'b1;
      pend_word_nxt = word_b_r;
      overrun_nxt   = pend_r && !buf_in_ready;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pend_r      <= 1'b0;
      pend_word_r <= FRAME_ZERO;
      overrun_r   <= 1'b0;
    end else begin
      pend_r      <= pend_nxt;
      pend_word_r <= pend_word_nxt;
      overrun_r   <= overrun_nxt;
    end
  end

  pair_buffer u_cmd_buf (
    .clk       (SYS_CLK),
    .rst       (RST),
    .in_valid  (pend_r),
    .in_ready  (buf_in_ready),
    .in_data   (pend_word_r),
    .out_valid (buf_out_valid),
    .out_ready (CMD_READY),
    .out_data  (buf_out_data)
  );

  assign CMD_VALID   = buf_out_valid;
  assign CMD_DATA    = buf_out_data;
  assign CMD_OVERRUN = overrun_r;

  // ----------------------------------------------------------------
  // Interrupt pin drive
  // ----------------------------------------------------------------
  logic irq_o_r;
  logic irq_o_nxt;
  logic irq_oe_r;
  logic irq_oe_nxt;

  always_comb begin
    if (IRQ_PUSH_PULL == DRIVE_PUSH_PULL) begin
      irq_o_nxt  = !IRQ_REQUEST;
      irq_oe_nxt = 1'b1;
    end else begin
      irq_o_nxt  = 1'b0;
      irq_oe_nxt = IRQ_REQUEST;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      irq_o_r  <= 1'b1;
      irq_oe_r <= 1'b0;
    end else begin
      irq_o_r  <= irq_o_nxt;
      irq_oe_r <= irq_oe_nxt;
    end
  end

  assign INTERRUPT_REQUEST_N_O  = irq_o_r;
  assign INTERRUPT_REQUEST_N_OE = irq_oe_r;

endmodule

// File: tb/spi_chain_slave_props.sv
`timescale 1ns/1ps
module spi_chain_slave_props (
  input wire logic              SYS_CLK,
  input wire logic              RST,
  input wire logic              SLAVE_SELECT_N,
  input wire logic              SLAVE_OUT_OE,
  input wire logic              CMD_VALID,
  input wire logic              CMD_READY,
  input spi_chain_pkg::frame_t  CMD_DATA,
  input wire logic              CMD_OVERRUN,
  input wire logic              IRQ_REQUEST,
  input wire logic              IRQ_PUSH_PULL,
  input wire logic              INTERRUPT_REQUEST_N_O,
  input wire logic              INTERRUPT_REQUEST_N_OE
);
  import spi_chain_pkg::*;
  // --------------------------------
  // Port relations
  // --------------------------------
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  property p_oe_off; SLAVE_SELECT_N |-> !SLAVE_OUT_OE; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output driven while deselected");
  property p_oe_rise; $rose(SLAVE_OUT_OE) |-> !SLAVE_SELECT_N; endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("output enabled outside frame");
  property p_oe_hold;
    !SLAVE_SELECT_N && SLAVE_OUT_OE |=> SLAVE_OUT_OE || SLAVE_SELECT_N;
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("output dropped inside frame");
  property p_pp;
    IRQ_PUSH_PULL |=> INTERRUPT_REQUEST_N_OE
      && INTERRUPT_REQUEST_N_O == !$past(IRQ_REQUEST);
  endproperty
  a_pp: assert property (p_pp)
    else $error("push-pull interrupt drive wrong");
  property p_od;
    !IRQ_PUSH_PULL |=> !INTERRUPT_REQUEST_N_O
      && INTERRUPT_REQUEST_N_OE == $past(IRQ_REQUEST);
  endproperty
  a_od: assert property (p_od)
    else $error("open-drain interrupt drive wrong");
  property p_hold;
    CMD_VALID && !CMD_READY |=> CMD_VALID && $stable(CMD_DATA);
  endproperty
  a_hold: assert property (p_hold)
    else $error("command word lost before taken");
  property p_close; $rose(SLAVE_SELECT_N) |-> ##[1:12] CMD_VALID; endproperty
  a_close: assert property (p_close)
    else $error("no command after select release");
  property p_ovr; CMD_OVERRUN |-> CMD_VALID ##1 !CMD_OVERRUN; endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun pulse wrong");
  c_cmd: cover property ($rose(CMD_VALID));
  c_ovr: cover property (CMD_OVERRUN);
  c_oe: cover property ($rose(SLAVE_OUT_OE));
  c_pop: cover property (CMD_VALID && CMD_READY);
endmodule

bind spi_chain_slave spi_chain_slave_props u_spi_chain_slave_props (
  .SYS_CLK, .RST, .SLAVE_SELECT_N, .SLAVE_OUT_OE, .CMD_VALID, .CMD_READY,
  .CMD_DATA, .CMD_OVERRUN, .IRQ_REQUEST, .IRQ_PUSH_PULL,
  .INTERRUPT_REQUEST_N_O, .INTERRUPT_REQUEST_N_OE);

// File: tb/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  output logic      sclk,
  output logic      sel_n,
  output logic      mosi,
  input wire logic  so_o,
  input wire logic  so_oe
);
  // --------------------------------
  // Mode 3 host, clock idles high
  // --------------------------------
  wire so_line = so_oe ? so_o : ~so_o;
  initial begin
    sclk = 1'b1;
    sel_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic xfer(input int n, input int half, input logic [95:0] tx,
                      output logic [95:0] rx);
    rx = '0;
    sel_n = 1'b0;
    #30;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      #half;
      sclk = 1'b1;
      rx[i] = so_line;
      #half;
    end
    sel_n = 1'b1;
    mosi = ~mosi;
    #60;
  endtask
endmodule

// File: tb/spi_chain_slave_test.sv
`timescale 1ns/1ps
module spi_chain_slave_test;
  import spi_chain_pkg::*;
  logic        sys_clk, rst, cmd_ready, irq_request, irq_push_pull;
  logic        so_o, so_oe, cmd_valid, cmd_overrun, irq_o, irq_oe;
  wire         sclk, sel_n, mosi;
  frame_t      reply_data, cmd_data;
  logic [95:0] rx;
  int          mismatches, tests_run, ovr_count;
  wire         irq_line = irq_oe ? irq_o : 1'b1;
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    if (rst) ovr_count <= 0;
    else if (cmd_overrun === 1'b1) ovr_count <= ovr_count + 1;
  spi_chain_slave u_spi_chain_slave (.SYS_CLK(sys_clk), .RST(rst),
    .SERIAL_CLK(sclk), .SLAVE_SELECT_N(sel_n), .SLAVE_IN(mosi),
    .SLAVE_OUT_O(so_o), .SLAVE_OUT_OE(so_oe), .REPLY_DATA(reply_data),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_DATA(cmd_data),
    .CMD_OVERRUN(cmd_overrun), .IRQ_REQUEST(irq_request),
    .IRQ_PUSH_PULL(irq_push_pull), .INTERRUPT_REQUEST_N_O(irq_o),
    .INTERRUPT_REQUEST_N_OE(irq_oe));
  spi_host_model u_spi_host_model (.sclk(sclk), .sel_n(sel_n),
    .mosi(mosi), .so_o(so_o), .so_oe(so_oe));
  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic check(input string what, input logic [95:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic pop(input frame_t exp);
    int i;
    i = 0;
    do begin
      tick(1);
      i++;
    end while (cmd_valid !== 1'b1 && i < 50);
    if (cmd_valid !== 1'b1) begin
      mismatches++;
      report_and_stop;
    end
    check("cmd_data", cmd_data, exp);
    cmd_ready = 1'b1;
    tick(1);
    cmd_ready = 1'b0;
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_irq;
    for (int m = 0; m < 4; m++) begin
      irq_push_pull = m[1];
      irq_request = m[0];
      tick(2);
      check("irq_oe", irq_oe, m[1] | m[0]);
      check("irq_o", irq_o, m[1] & !m[0]);
      check("irq_line", irq_line, !m[0]);
    end
  endtask
  task automatic t_frame;
    reply_data = 32'ha5c30f81;
    fork
      u_spi_host_model.xfer(32, 15, 96'h12345678, rx);
      begin
        #300;
        reply_data = 32'h0;
      end
    join
    check("reply", rx[31:0], 32'ha5c30f81);
    check("oe_idle", so_oe, 1'b0);
    pop(32'h12345678);
  endtask
  task automatic t_chain;
    reply_data = 32'h0badf00d;
    u_spi_host_model.xfer(96, 15, 96'h89abcdef_02468ace_13579bdf, rx);
    check("pass", rx, {32'h0badf00d, 64'h89abcdef_02468ace});
    pop(32'h13579bdf);
  endtask
  task automatic t_fill;
    for (int k = 1; k <= 4; k++)
      u_spi_host_model.xfer(32, 15, {64'h0, {8{k[3:0]}}}, rx);
    tick(20);
    check("overrun", ovr_count, 1);
    pop(32'h11111111);
    pop(32'h22222222);
    pop(32'h44444444);
    tick(4);
    check("drained", cmd_valid, 1'b0);
  endtask
  initial begin
    rst = 1'b1;
    cmd_ready = 1'b0;
    irq_request = 1'b0;
    irq_push_pull = 1'b1;
    reply_data = FRAME_ZERO;
    mismatches = 0;
    tests_run = 0;
    tick(12);
    rst = 1'b0;
    check("oe_reset", so_oe, 1'b0);
    check("valid_reset", cmd_valid, 1'b0);
    tick(4);
    t_irq;
    t_frame;
    t_chain;
    t_fill;
    report_and_stop;
  end
endmodule
